/* src/vta_table_access.sv */
// Functional notes
// - Age test bit shortens aging to test interval
// - Each command write launches one table access
// - Read result valid once pending clears
// - Direction bit one reads, zero writes
// - Select bit picks port table, else VLAN
// - Index picks entry; out-of-range ports ignored
// - Port entry: VID 11:0, priority 14:12
// - Default VID for untagged, null, or disabled
// - Default priority when no other source
// - Port VID resets to one, priority zero
// - Member bit admits ingress, joins egress
// - Non-member drops unless admit setting
// - Untag bits 16,14,12; member 17,15,13
// - Entry VID 11:0, zero disables
module vta_table_access #(
   parameter int VLANS = 16,
   parameter int PORTS = 3,
   parameter longint AGE_NORMAL_CYC = vta_pkg::AGE_NORMAL_CYC,
   parameter longint AGE_TEST_CYC = vta_pkg::AGE_TEST_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire logic [1:0] rx_port,
   input wire logic rx_tagged,
   input wire logic [11:0] rx_vid,
   input wire logic tag_processing_off,
   input wire logic [PORTS-1:0] admit_outsider_config,
   input wire logic other_prio_sel,
   input wire logic [2:0] other_prio,
   output logic cls_valid,
   output logic [11:0] cls_vid,
   output logic [2:0] cls_prio,
   output logic cls_admit,
   output logic [PORTS-1:0] cls_egress_member,
   output logic [PORTS-1:0] cls_egress_untag,
   output logic age_tick
);
   import vta_pkg::*;

   vta_state_type state; // Command sequencer
   logic short_aging_test; // Aging test control
   logic [ENTRY_W-1:0] wr_data; // Write data register
   logic cmd_rnw; // Latched direction
   logic cmd_sel; // Latched table select
   logic [CMD_IDX_MSB:0] cmd_idx; // Latched index
   logic pending; // Operation pending flag
   logic [ENTRY_W-1:0] read_data; // Read data register
   logic [PORTS-1:0][11:0] pvid; // Port default VIDs
   logic [PORTS-1:0][2:0] pprio; // Port default priorities
   logic cmd_hit; // Access targets command register
   logic cmd_go; // Command write accepted
   logic wr_go; // Any write accepted
   logic vlan_we; // VLAN table write strobe
   logic port_we; // Port table write strobe
   logic mem_re; // VLAN table read strobe
   logic port_ok; // Latched index is a real port
   logic [ENTRY_W-1:0] mem_rdata; // VLAN table read word
   logic [11:0] look_vid; // Classifier VID
   logic look_hit; // VLAN entry found
   logic [ENTRY_W-1:0] look_entry; // Matched VLAN entry
   logic [PORTS-1:0] look_member; // Membership of matched entry
   logic [PORTS-1:0] look_untag; // Untag bits of matched entry
   logic rx_port_ok; // Ingress port in range
   logic [11:0] rx_pvid; // Default VID of ingress port
   logic [2:0] rx_pprio; // Default priority of ingress port
   logic [31:0] next_prdata; // Read mux
   logic next_pslverr; // Unmapped address

   // A second command is held off rather than dropped,
   // so software never loses a launch
   // Command write stalls while an access is in flight
   assign cmd_hit = paddr == ADDR_TABLE_COMMAND;
   assign pready = !(psel && penable && pwrite && cmd_hit && pending);
   assign wr_go = psel && penable && pwrite && pready && !pslverr;
   assign cmd_go = wr_go && cmd_hit;
   assign port_ok = cmd_idx < (CMD_IDX_MSB + 1)'(PORTS);

   // Strobes issued in the run state
   assign vlan_we = state == ST_RUN && !cmd_rnw && !cmd_sel;
   assign port_we = state == ST_RUN && !cmd_rnw && cmd_sel && port_ok;
   assign mem_re = state == ST_RUN && cmd_rnw && !cmd_sel;

   // Reserved bits read as zero; unmapped offsets answer
   // with an error and write nothing
   // Read mux and decode, sampled in the setup phase
   always_comb begin
      next_prdata = WORD_RESET;
      next_pslverr = 1'b0;
      case (paddr)
         ADDR_AGING_CONFIG: next_prdata[AGE_TEST_BIT] = short_aging_test;
         ADDR_TABLE_COMMAND: begin
            next_prdata[CMD_RNW_BIT] = cmd_rnw;
            next_prdata[CMD_SEL_BIT] = cmd_sel;
            next_prdata[CMD_IDX_MSB:0] = cmd_idx;
         end
         ADDR_TABLE_WRITE_DATA: next_prdata[ENTRY_W-1:0] = wr_data;
         ADDR_TABLE_READ_DATA: next_prdata[ENTRY_W-1:0] = read_data;
         ADDR_TABLE_COMMAND_STATUS: next_prdata[STS_PENDING_BIT] = pending;
         default: next_pslverr = 1'b1;
      endcase
   end

   // Registered read data and error answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= WORD_RESET;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? WORD_RESET : next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // Aging configuration register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         short_aging_test <= 1'b0;
      end else if (wr_go && paddr == ADDR_AGING_CONFIG) begin
         short_aging_test <= pwdata[AGE_TEST_BIT];
      end
   end

   // Only the low eighteen bits are stored
   // Write data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_data <= ENTRY_RESET;
      end else if (wr_go && paddr == ADDR_TABLE_WRITE_DATA) begin
         wr_data <= pwdata[ENTRY_W-1:0];
      end
   end

   // Command register fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_rnw <= 1'b0;
         cmd_sel <= 1'b0;
         cmd_idx <= '0;
      end else if (cmd_go) begin
         cmd_rnw <= pwdata[CMD_RNW_BIT];
         cmd_sel <= pwdata[CMD_SEL_BIT];
         cmd_idx <= pwdata[CMD_IDX_MSB:0];
      end
   end

   // Fixed two-cycle access keeps the pending window
   // short and known to software
   // Sequencer: run the access, then latch and finish
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: if (cmd_go) state <= ST_RUN;
            ST_RUN: state <= ST_DONE;
            ST_DONE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Set wins over clear, though both cannot meet: a
   // command is held off while the flag is high
   // Pending flag spans the whole access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending <= 1'b0;
      end else if (cmd_go) begin
         pending <= 1'b1;
      end else if (state == ST_DONE) begin
         pending <= 1'b0;
      end
   end

   // Read result latched on the same edge that pending drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_data <= ENTRY_RESET;
      end else if (state == ST_DONE && cmd_rnw) begin
         if (!cmd_sel) begin
            read_data <= mem_rdata;
         end else if (port_ok) begin
            read_data <= {3'h0, pprio[cmd_idx[1:0]],
                          pvid[cmd_idx[1:0]]};
         end else begin
            read_data <= ENTRY_RESET;
         end
      end
   end

   // Port default table, one entry per port
   for (genvar p = 0; p < PORTS; p++) begin : g_port
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pvid[p] <= PVID_RESET;
            pprio[p] <= PRIO_RESET;
         end else if (port_we && cmd_idx == (CMD_IDX_MSB + 1)'(p)) begin
            pvid[p] <= wr_data[VID_MSB:0];
            pprio[p] <= wr_data[PRIO_MSB:PRIO_LSB];
         end
      end
      // Entry bit pairs per port
      assign look_member[p] = look_entry[MEMBER_BASE + 2 * p];
      assign look_untag[p] = look_entry[UNTAG_BASE + 2 * p];
   end

   // VLAN membership table
   vta_vlan_table #(
      .ENTRIES(VLANS),
      .AW(CMD_IDX_MSB + 1)
   ) u_vlan_table (
      .pclk(pclk),
      .presetn(presetn),
      .we(vlan_we),
      .waddr(cmd_idx),
      .wdata(wr_data),
      .re(mem_re),
      .raddr(cmd_idx),
      .rdata(mem_rdata),
      .look_vid(look_vid),
      .look_hit(look_hit),
      .look_entry(look_entry)
   );

   // Aging interval divider
   vta_age_timer #(
      .NORMAL_CYC(AGE_NORMAL_CYC),
      .TEST_CYC(AGE_TEST_CYC)
   ) u_age_timer (
      .pclk(pclk),
      .presetn(presetn),
      .short_test(short_aging_test),
      .tick(age_tick)
   );

   // Ingress defaults for the arriving port
   // Port three is not a real port: defaults, no admit
   assign rx_port_ok = rx_port < 2'(PORTS);
   assign rx_pvid = rx_port_ok ? pvid[rx_port] : PVID_RESET;
   assign rx_pprio = rx_port_ok ? pprio[rx_port] : PRIO_RESET;
   assign look_vid = (tag_processing_off || !rx_tagged ||
                      rx_vid == 12'h000) ? rx_pvid : rx_vid;

   // Registered classification result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cls_valid <= 1'b0;
         cls_vid <= 12'h000;
         cls_prio <= 3'h0;
         cls_admit <= 1'b0;
         cls_egress_member <= '0;
         cls_egress_untag <= '0;
      end else begin
         cls_valid <= rx_valid;
         if (rx_valid) begin
            cls_vid <= look_vid;
            cls_prio <= other_prio_sel ? other_prio : rx_pprio;
            cls_admit <= rx_port_ok && ((look_hit && look_member[rx_port])
               || admit_outsider_config[rx_port]);
            cls_egress_member <= look_hit ? look_member : '0;
            cls_egress_untag <= look_hit ? look_untag : '0;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Checks of the command path
   a_cmd_launch: assert property (cmd_go |=> state == ST_RUN
      && pending ##1 state == ST_DONE) else $error("command not launched");
   a_read_latch: assert property (state == ST_DONE && cmd_rnw
      && !cmd_sel |=> read_data == $past(mem_rdata) && !pending)
      else $error("read result not latched at completion");
   a_rnw_decode: assert property (state == ST_RUN && cmd_rnw
      |-> !vlan_we && !port_we ##1 $stable(pvid) && $stable(pprio))
      else $error("read wrote");
   a_table_sel: assert property (state == ST_RUN && !cmd_rnw
      && port_ok |-> (vlan_we != port_we) && (port_we == cmd_sel))
      else $error("wrong table selected");
   a_port_range: assert property (state == ST_RUN && cmd_sel
      && !port_ok |=> $stable(pvid) && $stable(pprio))
      else $error("out of range port changed");
   a_port_fields: assert property (port_we && cmd_idx == 4'h0
      |=> pvid[0] == $past(wr_data[11:0])
      && pprio[0] == $past(wr_data[14:12])) else $error("port fields");
   // Checks of the classifier and of the pending window
   a_default_vid: assert property (rx_valid && tag_processing_off
      && rx_port == 2'h0 |=> cls_vid == $past(pvid[0]))
      else $error("default VID not applied");
   a_default_prio: assert property (rx_valid && !other_prio_sel
      && rx_port == 2'h1 |=> cls_prio == $past(pprio[1]))
      else $error("default priority not applied");
   a_reset_defaults: assert property (disable iff (1'b0)
      $rose(presetn) |-> pvid == {PORTS{PVID_RESET}} && pprio == '0)
      else $error("port defaults wrong after reset");
   a_member_admit: assert property (rx_valid && rx_port == 2'h2
      && look_hit && look_entry[17] |=> cls_admit && cls_egress_member[2])
      else $error("member not admitted");
   a_outsider_drop: assert property (rx_valid && rx_port == 2'h2
      && !admit_outsider_config[2] && !(look_hit && look_entry[17])
      |=> !cls_admit && !cls_egress_member[2])
      else $error("non member admitted");
   a_pending_hold: assert property (cmd_go |=> pending [*2]
      ##1 !pending) else $error("pending timing wrong");

   // Further command and classifier checks
   a_single_launch: assert property (cmd_go |=> !cmd_go
      ##1 !cmd_go) else $error("second launch during access");
   a_aging_write: assert property (wr_go && paddr == ADDR_AGING_CONFIG
      |=> short_aging_test == $past(pwdata[AGE_TEST_BIT]))
      else $error("aging control not written");
   a_port_readback: assert property (state == ST_DONE && cmd_rnw
      && cmd_sel && cmd_idx == 4'h2 |=> read_data ==
      {3'h0, $past(pprio[2]), $past(pvid[2])}) else $error("port read");
   a_null_vid: assert property (rx_valid && rx_vid == 12'h000
      && rx_port == 2'h1 |=> cls_vid == $past(pvid[1]))
      else $error("null VID not replaced");
   a_prio_override: assert property (rx_valid && other_prio_sel
      |=> cls_prio == $past(other_prio)) else $error("priority source");
   a_no_egress: assert property (rx_valid && !look_hit
      |=> cls_egress_member == '0 && cls_egress_untag == '0)
      else $error("egress set without entry");
   a_untag_copy: assert property (rx_valid && look_hit
      |=> cls_egress_untag == {$past(look_entry[16]),
      $past(look_entry[14]), $past(look_entry[12])})
      else $error("untag bits wrong");

   c_vlan_read: cover property (cmd_go && pwdata[5:4] == 2'b10
      ##3 !pending);
   c_port_write: cover property (port_we ##2 !pending);
   c_admit: cover property (cls_valid && cls_admit);
   c_stall: cover property (psel && penable && !pready);
endmodule : vta_table_access

/* src/vta_pkg.sv */
package vta_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_AGING_CONFIG = 16'h1809;
   localparam logic [15:0] IDX_TABLE_COMMAND = 16'h180b;
   localparam logic [15:0] IDX_TABLE_WRITE_DATA = 16'h180c;
   localparam logic [15:0] IDX_TABLE_READ_DATA = 16'h180e;
   localparam logic [15:0] IDX_TABLE_COMMAND_STATUS = 16'h180f;
   localparam logic [15:0] ADDR_AGING_CONFIG = {IDX_AGING_CONFIG[13:0], 2'b00};
   localparam logic [15:0] ADDR_TABLE_COMMAND =
      {IDX_TABLE_COMMAND[13:0], 2'b00};
   localparam logic [15:0] ADDR_TABLE_WRITE_DATA =
      {IDX_TABLE_WRITE_DATA[13:0], 2'b00};
   localparam logic [15:0] ADDR_TABLE_READ_DATA =
      {IDX_TABLE_READ_DATA[13:0], 2'b00};
   localparam logic [15:0] ADDR_TABLE_COMMAND_STATUS =
      {IDX_TABLE_COMMAND_STATUS[13:0], 2'b00};
   // Field positions
   localparam int AGE_TEST_BIT = 0;
   localparam int CMD_RNW_BIT = 5;
   localparam int CMD_SEL_BIT = 4;
   localparam int CMD_IDX_MSB = 3;
   localparam int STS_PENDING_BIT = 0;
   localparam int VID_MSB = 11;
   localparam int PRIO_LSB = 12;
   localparam int PRIO_MSB = 14;
   localparam int ENTRY_W = 18;
   localparam int UNTAG_BASE = 12;
   localparam int MEMBER_BASE = 13;
   // Reset values
   localparam logic [11:0] PVID_RESET = 12'h001;
   localparam logic [2:0] PRIO_RESET = 3'h0;
   localparam logic [17:0] ENTRY_RESET = 18'h00000;
   localparam logic [31:0] WORD_RESET = 32'h00000000;
   // Timing
   localparam longint CLK_HZ = 50000000;
   localparam longint AGE_NORMAL_MIN = 5;
   localparam longint AGE_TEST_MS = 50;
   localparam longint AGE_NORMAL_CYC = AGE_NORMAL_MIN * 60 * CLK_HZ;
   localparam longint AGE_TEST_CYC = AGE_TEST_MS * CLK_HZ / 1000;
   localparam int AGE_CNT_W = 34;
   // Command sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DONE = 2'b10
   } vta_state_type;
endpackage : vta_pkg

/* src/vta_vlan_table.sv */
module vta_vlan_table #(
   parameter int ENTRIES = 16,
   parameter int AW = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [vta_pkg::ENTRY_W-1:0] wdata,
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [vta_pkg::ENTRY_W-1:0] rdata,
   input wire logic [11:0] look_vid,
   output logic look_hit,
   output logic [vta_pkg::ENTRY_W-1:0] look_entry
);
   import vta_pkg::*;

   logic [ENTRY_W-1:0] mem [ENTRIES]; // Entry storage
   logic [ENTRIES-1:0] match; // Per-entry VID match

   // One storage word and comparator per entry
   for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mem[i] <= ENTRY_RESET;
         end else if (we && waddr == AW'(i)) begin
            mem[i] <= wdata;
         end
      end
      // VID zero marks a disabled entry
      assign match[i] = (mem[i][VID_MSB:0] == look_vid) &&
                        (look_vid != 12'h000);
   end

   // Registered read port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= ENTRY_RESET;
      end else if (re) begin
         rdata <= mem[raddr];
      end
   end

   // Lowest matching entry wins
   always_comb begin
      look_hit = 1'b0;
      look_entry = ENTRY_RESET;
      for (int i = ENTRIES - 1; i >= 0; i--) begin
         if (match[i]) begin
            look_hit = 1'b1;
            look_entry = mem[i];
         end
      end
   end

   a_hit_vid: assert property (@(posedge pclk) disable iff (!presetn)
      look_hit |-> look_entry[VID_MSB:0] == look_vid && look_vid != 12'h000)
      else $error("lookup hit on wrong or null VID");
endmodule : vta_vlan_table

/* src/vta_age_timer.sv */
module vta_age_timer #(
   parameter longint NORMAL_CYC = vta_pkg::AGE_NORMAL_CYC,
   parameter longint TEST_CYC = vta_pkg::AGE_TEST_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic short_test,
   output logic tick
);
   import vta_pkg::*;

   logic [AGE_CNT_W-1:0] cnt; // Cycle counter
   logic [AGE_CNT_W-1:0] limit; // Terminal count

   // Test mode selects the short interval
   assign limit = short_test ? AGE_CNT_W'(TEST_CYC - 1) :
                               AGE_CNT_W'(NORMAL_CYC - 1);

   // Free-running divider, one-cycle tick at wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (cnt >= limit) begin
         cnt <= '0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
         tick <= 1'b0;
      end
   end

   a_age_period: assert property (@(posedge pclk) disable iff (!presetn)
      tick |-> $past(cnt) >= $past(limit))
      else $error("aging tick not at interval end");
   c_age_tick: cover property (@(posedge pclk) disable iff (!presetn)
      short_test && tick);
endmodule : vta_age_timer

/* sim/vlan_table_access_tb.sv */
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
   n_fail++; $display("wrong value %s exp %h got %h", nm, ex, got); end end

module vlan_table_access_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import vta_pkg::*;
   localparam int NORM = 40; // Shortened normal aging interval
   localparam int TST = 10; // Shortened test aging interval
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic rx_valid, rx_tagged, tag_processing_off, other_prio_sel;
   logic [1:0] rx_port;
   logic [11:0] rx_vid, cls_vid;
   logic [2:0] admit_outsider_config, other_prio, cls_prio;
   logic cls_valid, cls_admit, age_tick;
   logic [2:0] cls_egress_member, cls_egress_untag;
   int n_fail, check_count;
   int vlan_m[16]; // Model of the membership table
   int pvid_m[4]; // Model of default VIDs, port 3 fixed
   int prio_m[4]; // Model of default priorities
   logic [22:0] exp_q[$]; // Pending classifier results
   logic [31:0] q;
   logic e;
   int g;

   vta_table_access #(.AGE_NORMAL_CYC(NORM), .AGE_TEST_CYC(TST)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
      .rx_port(rx_port), .rx_tagged(rx_tagged), .rx_vid(rx_vid),
      .tag_processing_off(tag_processing_off),
      .admit_outsider_config(admit_outsider_config),
      .other_prio_sel(other_prio_sel), .other_prio(other_prio),
      .cls_valid(cls_valid), .cls_vid(cls_vid), .cls_prio(cls_prio),
      .cls_admit(cls_admit), .cls_egress_member(cls_egress_member),
      .cls_egress_untag(cls_egress_untag), .age_tick(age_tick));

   // Free-running bus clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Verdict and end of run
   task automatic results;
      if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   // Hung wait counts as a mismatch
   task automatic hang;
      n_fail++;
      results();
   endtask : hang

   // One APB transfer; hold keeps psel up for a following setup
   task automatic apb(input logic wr, input logic [15:0] a,
         input logic [31:0] d, output logic [31:0] rd, output logic err,
         input bit hold);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) hang();
      rd = prdata;
      err = pslverr;
      if (!hold) begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb

   // Poll the pending flag until the access is finished
   task automatic wait_idle;
      logic [31:0] s;
      logic x;
      int n;
      n = 0;
      do begin
         apb(1'b0, ADDR_TABLE_COMMAND_STATUS, 0, s, x, 1'b0);
         n++;
      end while (s[STS_PENDING_BIT] !== 1'b0 && n < 20);
      if (n >= 20) hang();
   endtask : wait_idle

   // Table read through command, status and read-data registers
   task automatic tbl_read(input logic sel, input logic [3:0] idx,
         output logic [31:0] rd);
      logic x;
      apb(1'b1, ADDR_TABLE_COMMAND, {26'h0, 1'b1, sel, idx}, rd, x, 1'b0);
      wait_idle();
      apb(1'b0, ADDR_TABLE_READ_DATA, 0, rd, x, 1'b0);
   endtask : tbl_read

   // Table write: data first, then the command
   task automatic tbl_write(input logic sel, input logic [3:0] idx,
         input logic [31:0] d);
      logic [31:0] r;
      logic x;
      apb(1'b1, ADDR_TABLE_WRITE_DATA, d, r, x, 1'b0);
      apb(1'b1, ADDR_TABLE_COMMAND, {26'h0, 1'b0, sel, idx}, r, x, 1'b0);
      wait_idle();
   endtask : tbl_write

   // Cycles between two consecutive aging ticks
   task automatic age_gap(output int gap);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (age_tick !== 1'b1 && n < 300);
      gap = 0;
      do begin
         @(posedge pclk);
         gap++;
      end while (age_tick !== 1'b1 && gap < 300);
      if (gap >= 300) hang();
   endtask : age_gap

   // Expected classifier result packed as hit,untag,member,admit,prio,vid
   function automatic logic [22:0] expect_cls(int p, logic tg, int v,
         logic off, logic os, int op, logic [2:0] adm);
      logic [31:0] ent;
      logic hit;
      int vid;
      logic [2:0] mem;
      ent = 0;
      hit = 0;
      vid = (tg && v != 0 && !off) ? v : pvid_m[p];
      for (int i = 0; i < 16; i++) begin
         if (!hit && vid != 0 && (vlan_m[i] & 'hfff) == vid) begin
            hit = 1'b1;
            ent = vlan_m[i];
         end
      end
      mem = {ent[17], ent[15], ent[13]};
      return {hit, ent[16], ent[14], ent[12], mem, p < 3 && (mem[p] | adm[p]),
         3'(os ? op : prio_m[p]), 12'(vid)};
   endfunction : expect_cls

   // Compare every classifier result with the queued expectation
   always @(posedge pclk) begin
      if (cls_valid === 1'b1) begin
         logic [22:0] x;
         logic [21:0] got;
         if (exp_q.size() == 0) begin
            `CHK("cls_valid", 1'b0, cls_valid)
         end else begin
            x = exp_q.pop_front();
            got = {cls_egress_untag, cls_egress_member, cls_admit, cls_prio,
               cls_vid};
            `CHK("classify", x[21:0], got)
         end
      end
   end

   // Main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {rx_valid, rx_port, rx_tagged, rx_vid, tag_processing_off} = '0;
      {admit_outsider_config, other_prio_sel, other_prio} = '0;
      n_fail = 0;
      check_count = 0;
      void'($urandom(32'he987));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (vlan_m[i]) vlan_m[i] = 0;
      for (int p = 0; p < 4; p++) begin
         pvid_m[p] = 1;
         prio_m[p] = 0;
         tbl_read(1'b1, 4'(p), q);
         `CHK("port reset", 32'(p < 3), q)
      end
      apb(1'b0, ADDR_AGING_CONFIG, 0, q, e, 1'b0);
      `CHK("aging reset", 32'h00000000, q)
      // Unmapped write launches nothing
      apb(1'b1, 16'h6028, 32'h00000020, q, e, 1'b0);
      `CHK("unmapped err", 1'b1, e)
      apb(1'b0, ADDR_TABLE_COMMAND_STATUS, 0, q, e, 1'b0);
      `CHK("no pending", 32'h00000000, q)
      // Aging interval, test then normal
      apb(1'b1, ADDR_AGING_CONFIG, 32'hffffffff, q, e, 1'b0);
      apb(1'b0, ADDR_AGING_CONFIG, 0, q, e, 1'b0);
      `CHK("aging cfg", 32'h00000001, q)
      age_gap(g);
      age_gap(g);
      `CHK("test gap", TST, g)
      apb(1'b1, ADDR_AGING_CONFIG, 0, q, e, 1'b0);
      age_gap(g);
      age_gap(g);
      `CHK("normal gap", NORM, g)
      // Fill every VLAN entry, then read all back
      for (int i = 0; i < 16; i++) begin
         vlan_m[i] = ($urandom % 4 == 0) ? 0 : 1 + $urandom % 20;
         vlan_m[i] |= $urandom & 'h3f000;
         tbl_write(1'b0, 4'(i), 32'(vlan_m[i]) | 32'hfffc0000);
      end
      for (int i = 15; i >= 0; i--) begin
         tbl_read(1'b0, 4'(i), q);
         `CHK("vlan entry", 32'(vlan_m[i]), q)
      end
      // Port defaults, nonzero and not all ones, junk above bit 14
      for (int p = 0; p < 3; p++) begin
         pvid_m[p] = 1 + $urandom % 20;
         prio_m[p] = $urandom % 8;
         tbl_write(1'b1, 4'(p), (32'($urandom) << 15) | 32'(pvid_m[p]) |
            32'(prio_m[p] << PRIO_LSB));
         tbl_read(1'b1, 4'(p), q);
         `CHK("port entry", 32'(pvid_m[p] | prio_m[p] << 12), q)
      end
      tbl_write(1'b1, 4'hd, 32'h00007fff);
      tbl_read(1'b1, 4'hd, q);
      `CHK("bad port", 32'h00000000, q)
      // Command written while the previous one is still pending
      vlan_m[7] = 'h2a005;
      apb(1'b1, ADDR_TABLE_WRITE_DATA, 32'h0002a005, q, e, 1'b0);
      apb(1'b1, ADDR_TABLE_COMMAND, 32'h00000007, q, e, 1'b1);
      apb(1'b1, ADDR_TABLE_COMMAND, 32'h00000027, q, e, 1'b0);
      wait_idle();
      apb(1'b0, ADDR_TABLE_READ_DATA, 0, q, e, 1'b0);
      `CHK("stalled cmd", 32'h0002a005, q)
      // Random back-to-back classification traffic
      for (int k = 0; k < 400; k++) begin
         logic [31:0] r;
         r = $urandom;
         rx_valid <= r[0];
         rx_port <= r[31:30];
         rx_tagged <= r[1];
         rx_vid <= r[2] ? 12'h000 : 12'(1 + r[15:10] % 20);
         tag_processing_off <= (r[5:3] == 3'h0);
         other_prio_sel <= r[6];
         other_prio <= r[9:7];
         admit_outsider_config <= r[18:16];
         if (r[0]) exp_q.push_back(expect_cls(r[31:30], r[1],
            r[2] ? 0 : 1 + r[15:10] % 20, r[5:3] == 3'h0, r[6], r[9:7],
            r[18:16]));
         @(posedge pclk);
      end
      rx_valid <= 1'b0;
      repeat (4) @(posedge pclk);
      `CHK("left over", 0, exp_q.size())
      results();
   end
endmodule : vlan_table_access_tb
